// [logic/cfm_monitor.sv]
// Clock fault monitor top: monitors, lock state, status, AXI4-Lite slave
//
// Our own choices: the address map and the AXI4-Lite slave port.
module cfm_monitor
	import cfm_pkg::*;
#(
	parameter int AW = 8
) (
	input  wire logic          sys_clk_i,      // System clock, 10 MHz
	input  wire logic          rst_n_i,        // Sync reset, active low
	input  wire logic          clk_in_a_i,     // Input clock a
	input  wire logic          clk_in_b_i,     // Input clock b
	input  wire logic          clk_in_c_i,     // Input clock c
	input  wire logic          clk_in_d_i,     // Input d / feedback port
	input  wire logic          ref_pins_i,     // Reference pin clock
	input  wire logic          pd_in_i,        // Phase detector input
	input  wire logic          pd_fb_i,        // Phase detector feedback
	input  wire logic          switch_i,       // Input switch pulse
	input  wire logic          holdover_i,     // Holdover level
	output logic               lock_failure_o, // Lock failure pin
	output logic               irq_n_o,        // Interrupt, active low
	output logic               out_en_o,       // Output clocks enable
	input  wire logic [AW-1:0] s_axi_awaddr,   // Write address
	input  wire logic          s_axi_awvalid,  // Write address valid
	output logic               s_axi_awready,  // Write address ready
	input  wire logic [31:0]   s_axi_wdata,    // Write data
	input  wire logic [3:0]    s_axi_wstrb,    // Write strobes
	input  wire logic          s_axi_wvalid,   // Write data valid
	output logic               s_axi_wready,   // Write data ready
	output logic [1:0]         s_axi_bresp,    // Write response
	output logic               s_axi_bvalid,   // Write response valid
	input  wire logic          s_axi_bready,   // Write response ready
	input  wire logic [AW-1:0] s_axi_araddr,   // Read address
	input  wire logic          s_axi_arvalid,  // Read address valid
	output logic               s_axi_arready,  // Read address ready
	output logic [31:0]        s_axi_rdata,    // Read data
	output logic [1:0]         s_axi_rresp,    // Read response
	output logic               s_axi_rvalid,   // Read valid
	input  wire logic          s_axi_rready    // Read ready
);

	// ******************************
	// Registers
	// ******************************
	logic [31:0]        ctrl_reg;
	logic [4:0]         msdis_reg;
	logic [19:0]        sens_reg;
	logic [13:0]        win_reg;
	logic [13:0]        hyst_reg;
	logic [23:0]        gate_reg;
	logic [16:0]        set_reg;
	logic [16:0]        clr_reg;
	logic [23:0]        dly_reg;
	logic [CFM_NST-1:0] live_reg;
	logic [CFM_NST-1:0] sticky_reg;
	logic [CFM_NST-1:0] mask_reg;
	logic [CFM_NST-1:0] live_next;
	logic [CFM_NST-1:0] wclr;

	logic       wr_en;
	logic       wr_ok;
	logic       rd_ok;
	logic [31:0] rd_next;
	logic [2:0] osel;
	logic [1:0] psel;

	assign osel = ctrl_reg[CFM_OSEL_LSB +: 3];
	assign psel = ctrl_reg[CFM_PSEL_LSB +: 2];

	// ******************************
	// Channels
	// ******************************
	logic [6:0]  sig;
	logic [6:0]  edg;
	logic [6:0]  miss;
	logic [6:0]  pend;
	logic [23:0] pcnt [7];
	logic [23:0] fcnt [7];
	logic [3:0]  sens [7];
	logic [6:0]  mdis;

	// Order: inputs a..d, reference pins, phase detector input, feedback
	assign sig = {pd_fb_i, pd_in_i, ref_pins_i, clk_in_d_i, clk_in_c_i,
		clk_in_b_i, clk_in_a_i};
	assign mdis = {2'b11, msdis_reg};

	logic ogate_end;
	logic fgate_end;
	logic lgate_end;
	assign pend = {lgate_end, lgate_end, {5{ogate_end}}};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_ch
			assign sens[gi] = (gi < 5) ? sens_reg[(gi % 5)*4 +: 4] : 4'h0;
			cfm_chan #(.CW(24)) u_ch (
				.sys_clk_i  (sys_clk_i),
				.rst_n_i    (rst_n_i),
				.sig_i      (sig[gi]),
				.sens_i     (sens[gi]),
				.dis_i      (mdis[gi]),
				.prec_end_i (pend[gi]),
				.fast_end_i (fgate_end),
				.edge_o     (edg[gi]),
				.miss_o     (miss[gi]),
				.prec_cnt_o (pcnt[gi]),
				.fast_cnt_o (fcnt[gi])
			);
		end
	endgenerate

	// ******************************
	// Gate timing
	// ******************************
	logic        oref_edge;
	logic [23:0] ogc_reg;
	logic [15:0] fgc_reg;
	logic [23:0] lgc_reg;
	logic        oev_reg;
	logic        fev_reg;
	logic        lev_reg;

	// Zero-ppm reference: 4 picks the reference pins
	assign oref_edge = (osel > 3'h4) ? 1'b0 : edg[osel];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ogc_reg   <= 24'h00_0000;
			fgc_reg   <= 16'h0000;
			lgc_reg   <= 24'h00_0000;
			ogate_end <= 1'b0;
			fgate_end <= 1'b0;
			lgate_end <= 1'b0;
			oev_reg   <= 1'b0;
			fev_reg   <= 1'b0;
			lev_reg   <= 1'b0;
		end else begin
			ogate_end <= oref_edge && (ogc_reg + 24'h00_0001 >= gate_reg);
			fgate_end <= oref_edge && (fgc_reg + 16'h0001 >= CFM_FAST_GATE);
			lgate_end <= edg[5] && (lgc_reg + 24'h00_0001 >= gate_reg);
			oev_reg   <= ogate_end;
			fev_reg   <= fgate_end;
			lev_reg   <= lgate_end;
			if (oref_edge) begin
				ogc_reg <= (ogc_reg + 24'h00_0001 >= gate_reg) ? 24'h00_0000
					: ogc_reg + 24'h00_0001;
				fgc_reg <= (fgc_reg + 16'h0001 >= CFM_FAST_GATE) ? 16'h0000
					: fgc_reg + 16'h0001;
			end
			if (edg[5]) begin
				lgc_reg <= (lgc_reg + 24'h00_0001 >= gate_reg) ? 24'h00_0000
					: lgc_reg + 24'h00_0001;
			end
		end
	end

	// ******************************
	// Frequency monitors
	// ******************************
	logic [3:0]  oofp_reg;
	logic [3:0]  ooff_reg;
	logic [13:0] wlo;
	logic [63:0] whi_lim;
	logic [63:0] wlo_lim;
	logic [63:0] f_lim;

	assign wlo     = (hyst_reg > win_reg) ? 14'h0000 : win_reg - hyst_reg;
	assign whi_lim = cfm_mul(32'(win_reg), 32'(gate_reg));
	assign wlo_lim = cfm_mul(32'(wlo), 32'(gate_reg));
	assign f_lim   = CFM_FAST_PPM * {48'h0, CFM_FAST_GATE};

	generate
		for (gi = 0; gi < 4; gi++) begin : g_freq
			logic [63:0] pdev;
			logic [63:0] fdev;
			assign pdev = cfm_mul(32'(cfm_absd(pcnt[gi], gate_reg)),
				CFM_PPM16[31:0]);
			assign fdev = cfm_mul(32'(cfm_absd(fcnt[gi],
				{8'h00, CFM_FAST_GATE})), CFM_PPM[31:0]);
			always_ff @(posedge sys_clk_i) begin
				if (!rst_n_i) begin
					oofp_reg[gi] <= 1'b0;
					ooff_reg[gi] <= 1'b0;
				end else begin
					// Assert above window, release only at or below window-hyst
					if (oev_reg && pdev > whi_lim) begin
						oofp_reg[gi] <= 1'b1;
					end else if (oev_reg && pdev <= wlo_lim) begin
						oofp_reg[gi] <= 1'b0;
					end
					if (fev_reg) begin
						ooff_reg[gi] <= fdev > f_lim;
					end
				end
			end
		end
	endgenerate

	// ******************************
	// Lock state
	// ******************************
	cfm_lock_t   lk_reg;
	cfm_lock_t   lk_next;
	logic [23:0] tmr_reg;
	logic [63:0] ldev;
	logic        set_c;
	logic        clr_c;

	assign ldev  = cfm_mul(32'(cfm_absd(pcnt[6], pcnt[5])),
		CFM_PPM_TENTH[31:0]);
	assign set_c = lev_reg && ldev > cfm_mul(32'(set_reg), 32'(gate_reg));
	assign clr_c = lev_reg && ldev <= cfm_mul(32'(clr_reg), 32'(gate_reg));

	always_comb begin
		lk_next = lk_reg;
		case (lk_reg)
			CFM_LOCKED: begin
				if (switch_i || set_c) begin
					lk_next = CFM_FAIL;
				end
			end
			CFM_FAIL: begin
				if (clr_c && !switch_i) begin
					lk_next = (dly_reg == 24'h00_0000) ? CFM_LOCKED
						: CFM_HOLDOFF;
				end
			end
			CFM_HOLDOFF: begin
				if (switch_i || set_c) begin
					lk_next = CFM_FAIL;
				end else if (tmr_reg <= 24'h00_0001) begin
					lk_next = CFM_LOCKED;
				end
			end
			default: lk_next = CFM_FAIL;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			lk_reg         <= CFM_FAIL;
			tmr_reg        <= 24'h00_0000;
			lock_failure_o <= 1'b1;
		end else begin
			lk_reg         <= lk_next;
			lock_failure_o <= lk_next != CFM_LOCKED;
			if (lk_reg != CFM_HOLDOFF) begin
				tmr_reg <= dly_reg;
			end else begin
				tmr_reg <= tmr_reg - 24'h00_0001;
			end
		end
	end

	// ******************************
	// Status, sticky and interrupt
	// ******************************
	logic [3:0] gsup;
	logic [3:0] freq_live;

	// Gaps on the locked, selected input must not raise faults
	assign gsup = (ctrl_reg[CFM_GAP_BIT] && lk_reg == CFM_LOCKED)
		? (4'h1 << psel) : 4'h0;
	assign freq_live = ((oofp_reg & {4{~ctrl_reg[CFM_PDIS_BIT]}})
		| (ooff_reg & {4{~ctrl_reg[CFM_FDIS_BIT]}})) & ~gsup;
	assign live_next = {holdover_i, lk_reg != CFM_LOCKED, freq_live,
		miss[4], miss[3:0] & ~gsup};
	assign wclr = (wr_en && s_axi_awaddr == CFM_STICKY_OFF)
		? s_axi_wdata[CFM_NST-1:0] : '0;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			live_reg   <= '0;
			sticky_reg <= '0;
			irq_n_o    <= 1'b1;
			out_en_o   <= 1'b0;
		end else begin
			live_reg   <= live_next;
			// Set wins over clear; live level keeps it held
			sticky_reg <= (sticky_reg & ~(wclr & ~live_reg))
				| (live_next & ~live_reg);
			irq_n_o    <= ~|(sticky_reg & ~mask_reg);
			out_en_o   <= ~(live_reg[4] & ~ctrl_reg[CFM_KEEP_BIT]);
		end
	end

	// ******************************
	// AXI4-Lite write
	// ******************************
	assign wr_en = s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready;
	assign wr_ok = s_axi_awaddr <= CFM_MASK_OFF && s_axi_awaddr[1:0] == 2'h0;

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= CFM_RESP_OK;
		end else begin
			s_axi_awready <= !s_axi_awready && s_axi_awvalid
				&& s_axi_wvalid && !s_axi_bvalid;
			s_axi_wready  <= !s_axi_awready && s_axi_awvalid
				&& s_axi_wvalid && !s_axi_bvalid;
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? CFM_RESP_OK : CFM_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			ctrl_reg  <= CFM_CTRL_RST;
			msdis_reg <= 5'h00;
			sens_reg  <= CFM_SENS_RST;
			win_reg   <= CFM_WIN_RST;
			hyst_reg  <= CFM_HYST_RST;
			gate_reg  <= CFM_GATE_RST;
			set_reg   <= CFM_SET_RST;
			clr_reg   <= CFM_CLR_RST;
			dly_reg   <= 24'h00_0000;
			mask_reg  <= CFM_MASK_RST;
		end else if (wr_en && s_axi_wstrb == 4'hF) begin
			case (s_axi_awaddr)
				CFM_CTRL_OFF:   ctrl_reg  <= s_axi_wdata;
				CFM_MSDIS_OFF:  msdis_reg <= s_axi_wdata[4:0];
				CFM_MSSENS_OFF: sens_reg  <= s_axi_wdata[19:0];
				CFM_OOFWIN_OFF: begin
					win_reg  <= s_axi_wdata[13:0];
					hyst_reg <= s_axi_wdata[CFM_HYST_LSB +: 14];
				end
				CFM_GATE_OFF:   gate_reg  <= (s_axi_wdata[23:0] == 24'h0)
					? 24'h00_0001 : s_axi_wdata[23:0];
				CFM_LOLSET_OFF: set_reg   <= s_axi_wdata[16:0];
				CFM_LOLCLR_OFF: clr_reg   <= s_axi_wdata[16:0];
				CFM_LOLDLY_OFF: dly_reg   <= s_axi_wdata[23:0];
				CFM_MASK_OFF:   mask_reg  <= s_axi_wdata[CFM_NST-1:0];
				default:        ;
			endcase
		end
	end

	// ******************************
	// AXI4-Lite read
	// ******************************
	always_comb begin
		rd_ok   = 1'b1;
		rd_next = 32'h0000_0000;
		case (s_axi_araddr)
			CFM_CTRL_OFF:   rd_next = ctrl_reg;
			CFM_MSDIS_OFF:  rd_next = {27'h0, msdis_reg};
			CFM_MSSENS_OFF: rd_next = {12'h0, sens_reg};
			CFM_OOFWIN_OFF: rd_next = {2'h0, hyst_reg, 2'h0, win_reg};
			CFM_GATE_OFF:   rd_next = {8'h0, gate_reg};
			CFM_LOLSET_OFF: rd_next = {15'h0, set_reg};
			CFM_LOLCLR_OFF: rd_next = {15'h0, clr_reg};
			CFM_LOLDLY_OFF: rd_next = {8'h0, dly_reg};
			CFM_LIVE_OFF:   rd_next = {21'h0, live_reg};
			CFM_STICKY_OFF: rd_next = {21'h0, sticky_reg};
			CFM_MASK_OFF:   rd_next = {21'h0, mask_reg};
			default:        rd_ok   = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= CFM_RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid
				&& !s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_next;
				s_axi_rresp  <= rd_ok ? CFM_RESP_OK : CFM_RESP_ERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // cfm_monitor

// [logic/cfm_pkg.sv]
// Constants, register map and helpers of the clock fault monitor
package cfm_pkg;

	// ******************************
	// Register offsets
	// ******************************
	localparam logic [7:0] CFM_CTRL_OFF    = 8'h00;
	localparam logic [7:0] CFM_MSDIS_OFF   = 8'h04;
	localparam logic [7:0] CFM_MSSENS_OFF  = 8'h08;
	localparam logic [7:0] CFM_OOFWIN_OFF  = 8'h0C;
	localparam logic [7:0] CFM_GATE_OFF    = 8'h10;
	localparam logic [7:0] CFM_LOLSET_OFF  = 8'h14;
	localparam logic [7:0] CFM_LOLCLR_OFF  = 8'h18;
	localparam logic [7:0] CFM_LOLDLY_OFF  = 8'h1C;
	localparam logic [7:0] CFM_LIVE_OFF    = 8'h20;
	localparam logic [7:0] CFM_STICKY_OFF  = 8'h24;
	localparam logic [7:0] CFM_MASK_OFF    = 8'h28;

	// ******************************
	// Field positions and resets
	// ******************************
	localparam int CFM_KEEP_BIT  = 0;
	localparam int CFM_GAP_BIT   = 1;
	localparam int CFM_PDIS_BIT  = 5;
	localparam int CFM_FDIS_BIT  = 6;
	localparam int CFM_OSEL_LSB  = 2;
	localparam int CFM_PSEL_LSB  = 7;
	localparam int CFM_HYST_LSB  = 16;
	localparam int CFM_ST_MS     = 0;
	localparam int CFM_ST_FREQ   = 5;
	localparam int CFM_ST_LOCK   = 9;
	localparam int CFM_ST_HOLD   = 10;
	localparam int CFM_NST       = 11;
	localparam logic [31:0] CFM_CTRL_RST   = 32'h0000_0010;
	localparam logic [23:0] CFM_GATE_RST   = 24'h00_2710;
	localparam logic [13:0] CFM_WIN_RST    = 14'h0060;
	localparam logic [13:0] CFM_HYST_RST   = 14'h0020;
	localparam logic [16:0] CFM_SET_RST    = 17'h0000A;
	localparam logic [16:0] CFM_CLR_RST    = 17'h00001;
	localparam logic [19:0] CFM_SENS_RST   = 20'h1_1111;
	localparam logic [CFM_NST-1:0] CFM_MASK_RST = 11'h000;

	// ******************************
	// Timing and scaling
	// ******************************
	localparam logic [15:0] CFM_PER_INIT   = 16'h0040;
	localparam logic [15:0] CFM_FAST_GATE  = 16'h1000;
	localparam logic [63:0] CFM_PPM16      = 64'h0000_0000_00F4_2400;
	localparam logic [63:0] CFM_PPM_TENTH  = 64'h0000_0000_0098_9680;
	localparam logic [63:0] CFM_PPM        = 64'h0000_0000_000F_4240;
	localparam logic [63:0] CFM_FAST_PPM   = 64'h0000_0000_0000_0FA0;
	localparam logic [1:0]  CFM_RESP_OK    = 2'h0;
	localparam logic [1:0]  CFM_RESP_ERR   = 2'h2;

	typedef enum logic [2:0] {
		CFM_LOCKED  = 3'b001,
		CFM_FAIL    = 3'b010,
		CFM_HOLDOFF = 3'b100
	} cfm_lock_t;

	function automatic logic [63:0] cfm_mul(input logic [31:0] a,
		input logic [31:0] b);
		return {32'h0, a} * {32'h0, b};
	endfunction

	function automatic logic [23:0] cfm_absd(input logic [23:0] a,
		input logic [23:0] b);
		return (a > b) ? (a - b) : (b - a);
	endfunction

endpackage

// [logic/cfm_chan.sv]
// One monitored clock: edge detect, missing-signal check, edge counters
module cfm_chan
	import cfm_pkg::*;
#(
	parameter int CW = 24
) (
	input  wire logic          sys_clk_i,  // System clock
	input  wire logic          rst_n_i,    // Sync reset, active low
	input  wire logic          sig_i,      // Monitored clock, sampled
	input  wire logic [3:0]    sens_i,     // Missed periods tolerated, minus one
	input  wire logic          dis_i,      // Missing monitor disable
	input  wire logic          prec_end_i, // Long gate end
	input  wire logic          fast_end_i, // Short gate end
	output logic               edge_o,     // Rising edge strobe
	output logic               miss_o,     // Missing-signal level
	output logic [CW-1:0]      prec_cnt_o, // Edges in long gate
	output logic [CW-1:0]      fast_cnt_o  // Edges in short gate
);

	logic          sig_reg;
	logic [15:0]   cyc_reg;
	logic [15:0]   per_reg;
	logic [CW-1:0] pc_reg;
	logic [CW-1:0] fc_reg;
	logic [20:0]   lim;
	logic [CW-1:0] inc;

	assign inc = {{(CW-1){1'b0}}, edge_o};
	// Limit spans sens+2 periods: isolated misses pass
	assign lim = 21'(per_reg) * 21'({1'b0, sens_i} + 5'h02);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			sig_reg <= 1'b0;
			edge_o  <= 1'b0;
		end else begin
			sig_reg <= sig_i;
			edge_o  <= sig_i & ~sig_reg;
		end
	end

	// ******************************
	// Period measurement
	// ******************************
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			cyc_reg <= 16'h0000;
			per_reg <= CFM_PER_INIT;
			miss_o  <= 1'b0;
		end else begin
			if (edge_o) begin
				per_reg <= cyc_reg + 16'h0001;
				cyc_reg <= 16'h0000;
			end else if (cyc_reg != 16'hFFFF) begin
				cyc_reg <= cyc_reg + 16'h0001;
			end
			miss_o <= !dis_i && !edge_o && (21'(cyc_reg) >= lim);
		end
	end

	// ******************************
	// Edge counters
	// ******************************
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			pc_reg     <= '0;
			fc_reg     <= '0;
			prec_cnt_o <= '0;
			fast_cnt_o <= '0;
		end else begin
			if (prec_end_i) begin
				prec_cnt_o <= pc_reg + inc;
				pc_reg     <= '0;
			end else begin
				pc_reg <= pc_reg + inc;
			end
			if (fast_end_i) begin
				fast_cnt_o <= fc_reg + inc;
				fc_reg     <= '0;
			end else begin
				fc_reg <= fc_reg + inc;
			end
		end
	end

endmodule // cfm_chan

// [tb/cfm_chk_monitor.sv]
// Checker of bus handshakes and lock pin of the clock fault monitor
module cfm_chk (
	input  wire logic        sys_clk_i,      // Clock
	input  wire logic        rst_n_i,        // Reset, active low
	input  wire logic        switch_i,       // Input switch pulse
	input  wire logic        lock_failure_o, // Lock failure pin
	input  wire logic        s_axi_awvalid,  // Write address valid
	input  wire logic        s_axi_awready,  // Write address ready
	input  wire logic        s_axi_wvalid,   // Write data valid
	input  wire logic        s_axi_wready,   // Write data ready
	input  wire logic        s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [1:0]  s_axi_bresp,    // Write response
	input  wire logic        s_axi_arvalid,  // Read address valid
	input  wire logic        s_axi_arready,  // Read address ready
	input  wire logic        s_axi_rvalid,   // Read valid
	input  wire logic        s_axi_rready,   // Read ready
	input  wire logic [31:0] s_axi_rdata     // Read data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_PAIR: assert property (s_axi_awready == s_axi_wready)
		else $error("address and data ready differ");
	AST_WR_RESP: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("no write response after write taken");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	AST_RD_RESP: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("no read data after read taken");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	AST_AR_PULSE: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read address ready longer than one cycle");
	AST_NO_WR_IN_B: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	AST_PULLIN: assert property (switch_i |-> ##[1:4] lock_failure_o)
		else $error("lock failure not raised after input switch");
endmodule // cfm_chk

bind cfm_monitor cfm_chk u_chk (
	.sys_clk_i(sys_clk_i),
	.rst_n_i(rst_n_i),
	.switch_i(switch_i),
	.lock_failure_o(lock_failure_o),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.s_axi_rdata(s_axi_rdata)
);

// [tb/cfm_clk_src.sv]
// Clock sources facing the fault monitor: inputs, reference, loop
module cfm_clk_src (
	input  wire logic [6:0] en_i,      // a,b,c,d,ref,pd_in,pd_fb on
	input  wire logic       c_slow_i,  // Input c at two thirds rate
	input  wire logic       fb_slow_i, // Feedback at two thirds rate
	input  wire logic       gap_i,     // Input b drops one pulse in eight
	output logic      [6:0] clk_o      // Clocks, same order
);
	timeunit 1ns;
	timeprecision 1ns;
	logic base = 1'b0;
	logic slow = 1'b0;
	// One common source keeps edge counts exact between channels
	always #200 base = ~base;
	always #300 slow = ~slow;
	logic [2:0] pc = 3'h0;
	// Counted on the low phase so a gated pulse never glitches
	always @(negedge base) pc <= pc + 3'h1;
	// Stopped clocks stand low
	always_comb begin
		clk_o = en_i & {7{base}};
		clk_o[1] = en_i[1] & base & ~(gap_i & (pc == 3'h0));
		clk_o[2] = en_i[2] & (c_slow_i ? slow : base);
		clk_o[6] = en_i[6] & (fb_slow_i ? slow : base);
	end
endmodule // cfm_clk_src

// [tb/cfm_monitor_tb.sv]
// Self-checking bench of the clock fault monitor over AXI4-Lite
module cfm_monitor_tb;
	import cfm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_i  = 1'b0;
	logic        rst_n_i    = 1'b0;
	logic [6:0]  en         = 7'h7F;
	logic        c_slow     = 1'b0;
	logic        fb_slow    = 1'b0;
	logic        gap        = 1'b0;
	logic        switch_i   = 1'b0;
	logic        holdover_i = 1'b0;
	logic [7:0]  awaddr     = 8'h00;
	logic [7:0]  araddr     = 8'h00;
	logic [31:0] wdata      = 32'h0;
	logic        awvalid    = 1'b0;
	logic        wvalid     = 1'b0;
	logic        bready     = 1'b0;
	logic        arvalid    = 1'b0;
	logic        rready     = 1'b0;
	logic [6:0]  clk;
	logic        lock_failure_o, irq_n_o, out_en_o;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	int          fails = 0;
	int          checks_done = 0;
	logic [7:0]  ra [7] = '{CFM_CTRL_OFF, CFM_MSSENS_OFF, CFM_OOFWIN_OFF,
		CFM_GATE_OFF, CFM_LOLSET_OFF, CFM_LOLCLR_OFF, CFM_MASK_OFF};
	logic [31:0] rv [7] = '{32'h10, 32'h1_1111, 32'h20_0060, 32'h2710,
		32'hA, 32'h1, 32'h0};

	initial begin
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	cfm_clk_src u_src (.en_i(en), .c_slow_i(c_slow), .fb_slow_i(fb_slow),
		.gap_i(gap), .clk_o(clk));

	cfm_monitor dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.clk_in_a_i(clk[0]), .clk_in_b_i(clk[1]), .clk_in_c_i(clk[2]),
		.clk_in_d_i(clk[3]), .ref_pins_i(clk[4]), .pd_in_i(clk[5]),
		.pd_fb_i(clk[6]), .switch_i(switch_i), .holdover_i(holdover_i),
		.lock_failure_o(lock_failure_o), .irq_n_o(irq_n_o),
		.out_en_o(out_en_o), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	// ************************************
	// Reporting
	// ************************************
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// ************************************
	// Bus cycles
	// ************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit dn;
		dn = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !dn; n++) begin
			@(posedge sys_clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				dn = 1;
			end
		end
		if (!dn) begin
			fails++;
			give_verdict();
		end
		// Spare edge so the next cycle never drives twice in one step
		@(posedge sys_clk_i);
	endtask

	task automatic rd(input logic [7:0] a);
		bit dn;
		dn = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !dn; n++) begin
			@(posedge sys_clk_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				dn = 1;
			end
		end
		if (!dn) begin
			fails++;
			give_verdict();
		end
		@(posedge sys_clk_i);
	endtask

	task automatic wait_live(input int b, input logic v, input int lim);
		for (int n = 0; n < lim; n++) begin
			rd(CFM_LIVE_OFF);
			if (d[b] === v) break;
		end
		chk("live bit", 32'(d[b]), 32'(v));
	endtask

	// ************************************
	// Scenarios
	// ************************************
	initial begin
		repeat (6) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		for (int i = 0; i < 7; i++) begin
			rd(ra[i]);
			chk("reset value", d, rv[i]);
		end
		rd(8'h2C);
		chk("unmapped read", 32'(r), 32'(CFM_RESP_ERR));
		wr(8'h30, 32'h1);
		chk("unmapped write", 32'(r), 32'(CFM_RESP_ERR));
		wr(CFM_GATE_OFF, 32'h10);
		wr(CFM_MASK_OFF, 32'h7FE);
		wr(CFM_STICKY_OFF, 32'h7FF);
		en[0] <= 1'b0;
		wait_live(0, 1'b1, 60);
		chk("irq low", 32'(irq_n_o), 32'h0);
		wr(CFM_STICKY_OFF, 32'h1);
		rd(CFM_STICKY_OFF);
		chk("sticky kept", 32'(d[0]), 32'h1);
		en[0] <= 1'b1;
		wait_live(0, 1'b0, 60);
		wr(CFM_STICKY_OFF, 32'h1);
		repeat (2) @(posedge sys_clk_i);
		chk("irq released", 32'(irq_n_o), 32'h1);
		rd(CFM_STICKY_OFF);
		chk("sticky cleared", 32'(d[0]), 32'h0);
		wr(CFM_MASK_OFF, 32'h7FF);
		en[0] <= 1'b0;
		wait_live(0, 1'b1, 60);
		chk("irq masked", 32'(irq_n_o), 32'h1);
		en[0] <= 1'b1;
		wr(CFM_MSDIS_OFF, 32'h2);
		en[1] <= 1'b0;
		repeat (300) @(posedge sys_clk_i);
		rd(CFM_LIVE_OFF);
		chk("disabled monitor", 32'(d[1]), 32'h0);
		en[1] <= 1'b1;
		en[4] <= 1'b0;
		wait_live(4, 1'b1, 80);
		chk("outputs off", 32'(out_en_o), 32'h0);
		wr(CFM_CTRL_OFF, 32'h11);
		repeat (3) @(posedge sys_clk_i);
		chk("outputs kept", 32'(out_en_o), 32'h1);
		en[4] <= 1'b1;
		wr(CFM_CTRL_OFF, 32'h10);
		wait_live(9, 1'b0, 100);
		chk("lock pin clear", 32'(lock_failure_o), 32'h0);
		switch_i <= 1'b1;
		@(posedge sys_clk_i);
		switch_i <= 1'b0;
		@(posedge sys_clk_i);
		chk("pull-in", 32'(lock_failure_o), 32'h1);
		wait_live(9, 1'b0, 100);
		fb_slow <= 1'b1;
		wait_live(9, 1'b1, 100);
		chk("lock pin set", 32'(lock_failure_o), 32'h1);
		wr(CFM_LOLDLY_OFF, 32'h12C);
		fb_slow <= 1'b0;
		repeat (200) @(posedge sys_clk_i);
		chk("hold-off", 32'(lock_failure_o), 32'h1);
		wait_live(9, 1'b0, 100);
		c_slow <= 1'b1;
		wait_live(7, 1'b1, 60);
		c_slow <= 1'b0;
		wait_live(7, 1'b0, 4000);
		rd(CFM_STICKY_OFF);
		chk("freq sticky", 32'(d[7]), 32'h1);
		wr(CFM_CTRL_OFF, 32'h92);
		gap <= 1'b1;
		repeat (300) @(posedge sys_clk_i);
		rd(CFM_LIVE_OFF);
		chk("gap suppressed", 32'(d[6]), 32'h0);
		wr(CFM_CTRL_OFF, 32'h90);
		wait_live(6, 1'b1, 100);
		gap <= 1'b0;
		wr(CFM_CTRL_OFF, 32'h08);
		c_slow <= 1'b1;
		wait_live(5, 1'b1, 100);
		wait_live(7, 1'b0, 100);
		wr(CFM_CTRL_OFF, 32'h68);
		wait_live(5, 1'b0, 10);
		// Precise check off: only the slow fast gate can flag input c
		wr(CFM_CTRL_OFF, 32'h30);
		wait_live(7, 1'b1, 11000);
		c_slow <= 1'b0;
		wr(CFM_CTRL_OFF, 32'h10);
		holdover_i <= 1'b1;
		wait_live(10, 1'b1, 10);
		give_verdict();
	end
endmodule // cfm_monitor_tb
